/* hw/orl_refresh_ctrl.sv */
`timescale 1ns/1ps
// Notes on behaviour
// R01: output codes live in a 32 by 16 bit two-port memory.
// R02: all scan and settling timing counts from the single system clock.
// R03: host and refresh ports never touch the memory in one cycle.
// R04: channels scanned 0 to 31 ascending, wrapping continuously.
// R05: DAC load and sample-hold select use the same channel in the same step.
// R06: each channel waits for DAC, demux and amplifier to settle.
// R07: host memory access waits for an interruptible scan point.
// R08: completion signalled to bus logic after the write, then scanning resumes.
// R09: scan halted for the track and convert phases of the loopback conversion.
// R10: each conversion freeze adds at most 15 us to the scan.
// R11: one control word write with both begin bits starts a conversion.
// R12: loopback channel taken from five low bits of the control word.
// R13: conversion runs settle, then track, then convert phases.
// R14: all conversion phases timed internally, no further host writes.
// R15: on command the monitor demux steers at once and settling begins.
// R16: host waits at least 5 ms before reading the result.
// R17: host keeps bus traffic low during the settling wait.
// R18: data-ready bit set when a result is available; host waits for it.
// R19: one shared switch control bit connects or isolates all outputs together.
// R20: exactly one output routed to the loopback converter line.
// R21: host loopback test writes a code and compares the converter result.
// R22: default full scan 3.4 ms; quick-scan bit gives about 0.85 ms.
// R23: begin bits strobe only on write, then read back as status.
// R24: reset clears all timers and control word flags.
// R25: data-ready cleared whenever a new conversion command is accepted.
module orl_refresh_ctrl
  import orl_pkg::*;
#(
  parameter int unsigned P_MUX_SETTLE_CYC = MUX_SETTLE_CYC
) (
  input  wire logic            i_sys_clk,
  input  wire logic            i_rst,
  input  wire orl_avl_req_type i_avl,
  output orl_avl_rsp_type      o_avl,
  input  wire logic [11:0]     i_adc_data,
  output orl_analog_type       o_analog
);

  localparam int unsigned SLOT_N_CYC = SLOT_NORMAL_CYC;
  localparam int unsigned SLOT_F_CYC = SLOT_FAST_CYC;

  typedef struct packed {
    orl_scan_type    scan;
    orl_conv_type    conv;
    logic [4:0]      chan;
    logic [19:0]     scan_cnt;
    logic [19:0]     conv_cnt;
    logic [15:0]     dac_word;
    logic [4:0]      mon_chan;
    logic            fast;
    logic            online;
    logic            ready;
    logic [11:0]     adc_word;
    logic            host_pend;
    logic            host_wr;
    logic [4:0]      host_addr;
    logic [15:0]     host_data;
    orl_avl_rsp_type avl;
    orl_analog_type  ana;
  } orl_state_type;

  orl_state_type state_r;
  orl_state_type state_nxt;

  // R01 data memory
  logic [15:0] data_mem [NUM_CHAN];
  logic        mem_we;
  logic [15:0] mem_rd;

  function automatic logic is_data_addr(input logic [7:0] a);
    return (a >= ADDR_DATA_LO) && (a[1:0] == 2'b00);
  endfunction

  function automatic logic [4:0] data_index(input logic [7:0] a);
    return a[6:2];
  endfunction

  // R03 single memory port per cycle
  // reads share the host slot but must never write
  assign mem_we = (state_r.scan == SC_HOSTWR) && state_r.host_wr;

  always_ff @(posedge i_sys_clk) begin
    if (mem_we) begin
      data_mem[state_r.host_addr] <= state_r.host_data;
    end
  end

  assign mem_rd = data_mem[(state_r.scan == SC_HOSTWR) ? state_r.host_addr : state_r.chan];

  always_comb begin
    logic [15:0] csr_rd;
    logic        cmd;
    logic [19:0] slot_len;
    logic        frozen;
    state_nxt = state_r;
    csr_rd    = 16'h0000;
    cmd       = 1'b0;
    // R02 slot from clock
    slot_len  = 20'(state_r.fast ? SLOT_F_CYC : SLOT_N_CYC);
    frozen    = 1'b0;

    // R23 begin bits read back as status
    csr_rd[CSR_CHAN_LSB +: CSR_CHAN_W] = state_r.mon_chan;
    csr_rd[CSR_ONLINE]     = state_r.online;
    csr_rd[CSR_FAST]       = state_r.fast;
    csr_rd[CSR_SETTLE_BIT] = (state_r.conv == CV_SETTLE);
    csr_rd[CSR_CONV_BIT]   = (state_r.conv == CV_TRACK) || (state_r.conv == CV_CONV);
    csr_rd[CSR_READY_BIT]  = state_r.ready;
    csr_rd[CSR_BUSY_BIT]   = (state_r.conv != CV_IDLE);

    state_nxt.avl.waitrequest = 1'b1;
    state_nxt.avl.readdata    = 32'h0000_0000;
    state_nxt.ana.dac_load    = 1'b0;

    // bus slave: one wait cycle on registers, data writes wait for the scan
    if ((i_avl.read || i_avl.write) && state_r.avl.waitrequest && !state_r.host_pend) begin
      if (i_avl.write && is_data_addr(i_avl.address)) begin
        // R07 defer to a safe scan point
        state_nxt.host_pend = 1'b1;
        state_nxt.host_addr = data_index(i_avl.address);
        state_nxt.host_wr   = 1'b1;
        state_nxt.host_data = i_avl.writedata[15:0];
      end else begin
        state_nxt.avl.waitrequest = 1'b0;
        if (i_avl.write && (i_avl.address == ADDR_CSR)) begin
          // R12 channel from low five bits
          state_nxt.mon_chan = i_avl.writedata[CSR_CHAN_LSB +: CSR_CHAN_W];
          state_nxt.fast     = i_avl.writedata[CSR_FAST];
          state_nxt.online   = i_avl.writedata[CSR_ONLINE];
          // R11 single-write command
          cmd = i_avl.writedata[CSR_SETTLE_BIT] && i_avl.writedata[CSR_CONV_BIT];
        end else if (i_avl.read) begin
          if (i_avl.address == ADDR_ID_WORD) begin
            state_nxt.avl.readdata = {16'h0000, BOARD_ID_VAL};
          end else if (i_avl.address == ADDR_CSR) begin
            state_nxt.avl.readdata = {16'h0000, csr_rd};
          end else if (i_avl.address == ADDR_ADC_DATA) begin
            state_nxt.avl.readdata = {20'h00000, state_r.adc_word};
          end else if (is_data_addr(i_avl.address)) begin
            // reads also wait for the host scan point, where the memory word is registered
            state_nxt.avl.waitrequest = 1'b1;
            state_nxt.host_pend       = 1'b1;
            state_nxt.host_addr       = data_index(i_avl.address);
            state_nxt.host_wr         = 1'b0;
          end
        end
      end
    end

    // conversion sequencer
    // R14 internally timed phases
    unique case (state_r.conv)
      CV_IDLE: begin
        state_nxt.conv_cnt = 20'h00000;
      end
      CV_SETTLE: begin
        if (state_r.conv_cnt >= 20'(P_MUX_SETTLE_CYC - 1)) begin
          state_nxt.conv     = CV_TRACK;
          state_nxt.conv_cnt = 20'h00000;
          state_nxt.ana.adc_track = 1'b1;
        end else begin
          state_nxt.conv_cnt = state_r.conv_cnt + 20'h00001;
        end
      end
      CV_TRACK: begin
        if (state_r.conv_cnt >= 20'(TRACK_CYC - 1)) begin
          state_nxt.conv     = CV_CONV;
          state_nxt.conv_cnt = 20'h00000;
          state_nxt.ana.adc_track   = 1'b0;
          state_nxt.ana.adc_convert = 1'b1;
        end else begin
          state_nxt.conv_cnt = state_r.conv_cnt + 20'h00001;
        end
      end
      CV_CONV: begin
        // R10 freeze bounded below 15 us
        if (state_r.conv_cnt >= 20'(CONV_CYC - 1)) begin
          state_nxt.conv     = CV_IDLE;
          state_nxt.conv_cnt = 20'h00000;
          state_nxt.ana.adc_convert = 1'b0;
          state_nxt.adc_word = i_adc_data;
          // R18 result ready flag
          state_nxt.ready    = 1'b1;
        end else begin
          state_nxt.conv_cnt = state_r.conv_cnt + 20'h00001;
        end
      end
    endcase

    if (cmd) begin
      // R13 settle phase first
      // R15 demux steers immediately
      state_nxt.conv     = CV_SETTLE;
      state_nxt.conv_cnt = 20'h00000;
      state_nxt.ana.adc_track   = 1'b0;
      state_nxt.ana.adc_convert = 1'b0;
      // R25 stale result cleared
      state_nxt.ready    = 1'b0;
    end

    // R09 freeze during track and convert
    // covers the entry and exit edges so no load meets track or convert
    frozen = (state_r.conv == CV_TRACK) || (state_r.conv == CV_CONV) ||
             (state_nxt.conv == CV_TRACK) || (state_nxt.conv == CV_CONV);

    // refresh scan
    unique case (state_r.scan)
      SC_LOAD: begin
        if (state_r.host_pend) begin
          state_nxt.scan = SC_HOSTWR;
        end else if (!frozen) begin
          // R05 code and select together
          state_nxt.dac_word     = mem_rd;
          state_nxt.ana.out_sel  = state_r.chan;
          state_nxt.ana.dac_load = 1'b1;
          state_nxt.scan         = SC_DAC;
          state_nxt.scan_cnt     = 20'h00000;
        end
      end
      SC_DAC: begin
        // R06 DAC settling
        if (!frozen) begin
          if (state_r.scan_cnt >= 20'(DAC_SETTLE_CYC - 1)) begin
            state_nxt.ana.demux_en = 1'b1;
            state_nxt.scan         = SC_HOLD;
            state_nxt.scan_cnt     = 20'h00000;
          end else begin
            state_nxt.scan_cnt = state_r.scan_cnt + 20'h00001;
          end
        end
      end
      SC_HOLD: begin
        // R06 demux and amplifier settling
        // R22 slot length sets scan period
        if (frozen) begin
          state_nxt.ana.demux_en = 1'b0;
        end else if (state_r.scan_cnt >= slot_len - 20'(DAC_SETTLE_CYC + 2)) begin
          state_nxt.ana.demux_en = 1'b0;
          // R04 ascending wrap
          state_nxt.chan         = state_r.chan + 5'd1;
          state_nxt.scan         = SC_LOAD;
          state_nxt.scan_cnt     = 20'h00000;
        end else begin
          state_nxt.ana.demux_en = 1'b1;
          state_nxt.scan_cnt     = state_r.scan_cnt + 20'h00001;
        end
      end
      SC_HOSTWR: begin
        // R08 complete then resume
        state_nxt.host_pend       = 1'b0;
        state_nxt.avl.waitrequest = 1'b0;
        state_nxt.avl.readdata    = {16'h0000, mem_rd};
        state_nxt.scan            = SC_LOAD;
      end
    endcase

    state_nxt.ana.dac_code   = state_nxt.dac_word[11:0];
    // R20 one monitored output
    state_nxt.ana.mon_sel    = state_nxt.mon_chan;
    // R19 output switch control
    state_nxt.ana.out_online = state_nxt.online;
  end

  // R24 reset clears timers and flags; data memory kept, waitrequest set high
  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      state_r <= '{scan: SC_LOAD, conv: CV_IDLE, avl: '{readdata: 32'h0000_0000,
                   waitrequest: 1'b1}, default: '0};
    end else begin
      state_r <= state_nxt;
    end
  end

  assign o_avl    = state_r.avl;
  assign o_analog = state_r.ana;

endmodule // orl_refresh_ctrl

/* hw/orl_pkg.sv */
package orl_pkg;

  // clock and timing
  localparam int unsigned CLK_HZ          = 200_000_000;
  localparam int unsigned SYS_CLK_HZ      = 16_000_000;
  localparam int unsigned SCAN_NORMAL_US  = 3400;
  localparam int unsigned SCAN_FAST_US    = 850;
  localparam int unsigned NUM_CHAN        = 32;
  localparam int unsigned SLOT_NORMAL_CYC = (CLK_HZ / 1_000_000) * SCAN_NORMAL_US / NUM_CHAN;
  localparam int unsigned SLOT_FAST_CYC   = (CLK_HZ / 1_000_000) * SCAN_FAST_US / NUM_CHAN;
  localparam int unsigned DAC_SETTLE_NS   = 1000;
  localparam int unsigned DAC_SETTLE_CYC  = (DAC_SETTLE_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
  localparam int unsigned FREEZE_MAX_US   = 15;
  localparam int unsigned TRACK_NS        = 2000;
  localparam int unsigned TRACK_CYC       = (TRACK_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
  localparam int unsigned CONV_NS         = 10000;
  localparam int unsigned CONV_CYC        = CONV_NS * (CLK_HZ / 1_000_000) / 1000;
  localparam int unsigned MUX_SETTLE_US   = 5000;
  localparam int unsigned MUX_SETTLE_CYC  = MUX_SETTLE_US * (CLK_HZ / 1_000_000);

  // avalon register map (byte addresses)
  localparam logic [7:0] ADDR_ID_WORD  = 8'h00;
  localparam logic [7:0] ADDR_CSR      = 8'h04;
  localparam logic [7:0] ADDR_ADC_DATA = 8'h08;
  localparam logic [7:0] ADDR_DATA_LO  = 8'h80;
  localparam logic [15:0] BOARD_ID_VAL = 16'h00A5;  // arbitrary value

  // control_status_word fields
  localparam int unsigned CSR_CHAN_LSB   = 0;
  localparam int unsigned CSR_CHAN_W     = 5;
  localparam int unsigned CSR_ONLINE     = 8;
  localparam int unsigned CSR_FAST       = 9;
  localparam int unsigned CSR_SETTLE_BIT = 12;
  localparam int unsigned CSR_CONV_BIT   = 13;
  localparam int unsigned CSR_READY_BIT  = 14;
  localparam int unsigned CSR_BUSY_BIT   = 15;

  typedef enum logic [3:0] {
    SC_LOAD   = 4'b0001,
    SC_DAC    = 4'b0010,
    SC_HOLD   = 4'b0100,
    SC_HOSTWR = 4'b1000
  } orl_scan_type;

  typedef enum logic [3:0] {
    CV_IDLE   = 4'b0001,
    CV_SETTLE = 4'b0010,
    CV_TRACK  = 4'b0100,
    CV_CONV   = 4'b1000
  } orl_conv_type;

  typedef struct packed {
    logic [7:0]  address;
    logic        read;
    logic        write;
    logic [31:0] writedata;
  } orl_avl_req_type;

  typedef struct packed {
    logic [31:0] readdata;
    logic        waitrequest;
  } orl_avl_rsp_type;

  typedef struct packed {
    logic [11:0] dac_code;
    logic        dac_load;
    logic [4:0]  out_sel;
    logic        demux_en;
    logic [4:0]  mon_sel;
    logic        adc_track;
    logic        adc_convert;
    logic        out_online;
  } orl_analog_type;

endpackage : orl_pkg

/* sim/orl_analog_model.sv */
`timescale 1ns/1ps
module orl_analog_model
  import orl_pkg::*;
(
  input  wire logic           i_sys_clk,
  input  wire orl_analog_type i_analog,
  output logic [11:0]         o_adc_data
);
  logic [11:0] held_r [32];
  logic [11:0] adc_r;

  always_ff @(posedge i_sys_clk) begin
    if (i_analog.demux_en)
      held_r[i_analog.out_sel] <= i_analog.dac_code;
    // one channel monitored; toggles when idle so stale data shows
    adc_r <= i_analog.adc_convert ? held_r[i_analog.mon_sel] : ~adc_r;
  end

  assign o_adc_data = adc_r;
endmodule // orl_analog_model

/* sim/orl_refresh_ctrl_chk.sv */
`timescale 1ns/1ps
module orl_refresh_ctrl_chk
  import orl_pkg::*;
(
  input wire logic            i_sys_clk,
  input wire logic            i_rst,
  input wire orl_avl_req_type i_avl,
  input wire orl_avl_rsp_type o_avl,
  input wire logic [11:0]     i_adc_data,
  input wire orl_analog_type  o_analog
);
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (i_rst);

  logic [4:0] last_ch_r;
  logic       seen_r;
  wire        taken   = (i_avl.read | i_avl.write) & o_avl.waitrequest;
  wire        cmd     = taken & i_avl.write & (i_avl.address == ADDR_CSR)
                        & i_avl.writedata[CSR_SETTLE_BIT] & i_avl.writedata[CSR_CONV_BIT];
  wire [4:0]  wr_chan = i_avl.writedata[CSR_CHAN_LSB +: CSR_CHAN_W];

  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      last_ch_r <= 5'h0;
      seen_r    <= 1'b0;
    end else if (o_analog.dac_load) begin
      last_ch_r <= o_analog.out_sel;
      seen_r    <= 1'b1;
    end
  end

  property p_ack_pulse; !o_avl.waitrequest |=> o_avl.waitrequest; endproperty
  a_ack_pulse: assert property (p_ack_pulse) else $error("ack longer than one cycle");
  property p_csr_ack; taken && i_avl.address == ADDR_CSR |=> !o_avl.waitrequest; endproperty
  a_csr_ack: assert property (p_csr_ack) else $error("csr access not answered");
  property p_mon_sel; cmd |=> o_analog.mon_sel == $past(wr_chan); endproperty
  a_mon_sel: assert property (p_mon_sel) else $error("monitor channel wrong");
  property p_scan_order;
    o_analog.dac_load && seen_r |-> o_analog.out_sel == last_ch_r + 5'h1;
  endproperty
  a_scan_order: assert property (p_scan_order) else $error("scan order broken");
  property p_freeze; o_analog.adc_track || o_analog.adc_convert |-> !o_analog.dac_load; endproperty
  a_freeze: assert property (p_freeze) else $error("refresh during conversion");
  property p_load_pulse; o_analog.dac_load |=> !o_analog.dac_load [*2]; endproperty
  a_load_pulse: assert property (p_load_pulse) else $error("no settle after load");
  property p_track_conv;
    $fell(o_analog.adc_track) && !$past(i_rst) |-> o_analog.adc_convert;
  endproperty
  a_track_conv: assert property (p_track_conv) else $error("convert not after track");
  property p_upper_zero;
    !o_avl.waitrequest && i_avl.read |-> o_avl.readdata[31:16] == 16'h0;
  endproperty
  a_upper_zero: assert property (p_upper_zero) else $error("upper read bits set");

  c_cmd: cover property (cmd);
  c_conv: cover property ($rose(o_analog.adc_convert));
  c_wrap: cover property (o_analog.dac_load && o_analog.out_sel == 5'h1F);
endmodule // orl_refresh_ctrl_chk

/* sim/tb_output_refresh_and_loopback_ctrl.sv */
`timescale 1ns/1ps
module tb_output_refresh_and_loopback_ctrl
  import orl_pkg::*;
;
  logic            i_sys_clk   = 1'b0;
  logic            i_rst       = 1'b1;
  orl_avl_req_type req         = '0;
  orl_avl_rsp_type rsp;
  logic [11:0]     adc;
  orl_analog_type  ana;
  int              fail_count  = 0;
  int              checks_done = 0;
  logic [31:0]     q;
  logic [4:0]      c;

  always #2.5 i_sys_clk = ~i_sys_clk;

  // short mux settle keeps the run brief
  orl_refresh_ctrl #(.P_MUX_SETTLE_CYC(50)) orl_refresh_ctrl_inst (
    .i_sys_clk(i_sys_clk), .i_rst(i_rst), .i_avl(req), .o_avl(rsp),
    .i_adc_data(adc), .o_analog(ana));
  orl_analog_model orl_analog_model_inst (
    .i_sys_clk(i_sys_clk), .i_analog(ana), .o_adc_data(adc));

  task automatic stop_test();
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp) begin
      $display("unexpected %s: expected %h seen %h", what, exp, got);
      fail_count++;
    end
  endtask

  task automatic give_up(input string what);
    $display("unexpected %s: expected done seen timeout", what);
    fail_count++;
    stop_test();
  endtask

  // memory accesses may wait a whole scan slot
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge i_sys_clk);
    req.address   <= a;
    req.write     <= wr;
    req.read      <= ~wr;
    req.writedata <= d;
    // rsp read right after the edge holds the value sampled at that edge
    do begin
      @(posedge i_sys_clk);
      n++;
    end while (rsp.waitrequest !== 1'b0 && n < 30000);
    if (n >= 30000) give_up("bus answer");
    q = rsp.readdata;
    req.read  <= 1'b0;
    req.write <= 1'b0;
  endtask

  task automatic wait_chan(input logic want_demux);
    int n;
    n = 0;
    do begin
      @(negedge i_sys_clk);
      n++;
    end while (!(ana.out_sel === c && ana.demux_en === want_demux) && n < 30000);
    if (n >= 30000) give_up("channel refresh");
  endtask

  task automatic t_reset_state();
    bus(1'b0, ADDR_ID_WORD, 32'h0);
    check("board id", {16'h0, BOARD_ID_VAL}, q);
    bus(1'b0, ADDR_CSR, 32'h0);
    check("csr after reset", 32'h0, q);
  endtask

  task automatic t_modes();
    bus(1'b1, ADDR_CSR, 32'h300);
    @(negedge i_sys_clk);
    check("online", 32'h1, 32'(ana.out_online));
    bus(1'b0, ADDR_CSR, 32'h0);
    check("mode bits", 32'h300, q & 32'h300);
    bus(1'b1, 8'h40, 32'hFFFF);
    bus(1'b0, 8'h40, 32'h0);
    check("unmapped", 32'h0, q);
  endtask

  task automatic t_memory();
    for (int i = 0; i < 2; i++) begin
      c = i ? 5'h1F : 5'h0;
      bus(1'b1, ADDR_DATA_LO + {1'b0, c, 2'b00}, 32'hA50F ^ 32'(c));
      bus(1'b0, ADDR_DATA_LO + {1'b0, c, 2'b00}, 32'h0);
      check("data word", 32'hA50F ^ 32'(c), q);
    end
  endtask

  task automatic t_loopback();
    int n;
    @(negedge i_sys_clk);
    c = ana.out_sel + 5'h2;
    bus(1'b1, ADDR_DATA_LO + {1'b0, c, 2'b00}, 32'h5C3);
    wait_chan(1'b1);
    wait_chan(1'b0);
    bus(1'b1, ADDR_CSR, 32'h3300 | 32'(c));
    @(negedge i_sys_clk);
    check("monitor channel", 32'(c), 32'(ana.mon_sel));
    n = 0;
    // scaled settle wait, status polls only
    do begin
      bus(1'b0, ADDR_CSR, 32'h0);
      n++;
    end while (q[CSR_READY_BIT] !== 1'b1 && n < 3000);
    if (n >= 3000) give_up("data ready");
    bus(1'b0, ADDR_ADC_DATA, 32'h0);
    check("loopback code", 32'h5C3, q);
    bus(1'b1, ADDR_CSR, 32'h3300 | 32'(c));
    bus(1'b0, ADDR_CSR, 32'h0);
    check("ready after command", 32'h8000, q & 32'hC000);
  endtask

  initial begin
    repeat (2) @(posedge i_sys_clk);
    i_rst <= 1'b0;
    t_reset_state();
    t_modes();
    t_memory();
    t_loopback();
    stop_test();
  end
endmodule // tb_output_refresh_and_loopback_ctrl

bind orl_refresh_ctrl orl_refresh_ctrl_chk orl_refresh_ctrl_chk_inst (
  .i_sys_clk(i_sys_clk), .i_rst(i_rst), .i_avl(i_avl), .o_avl(o_avl),
  .i_adc_data(i_adc_data), .o_analog(o_analog));
